// >>> hw/mps_defines.svh
// Timing counts, default sizes and error codes for the motion program sequencer.
// Assumes inclusion by bare name from the sequencer module.
`ifndef MPS_DEFINES_SVH
`define MPS_DEFINES_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MPS_CLK_NS 50
`define MPS_MS_NS 1000000

// ----------------------------------------------------------------
// Default sizes
// ----------------------------------------------------------------
`define MPS_PROG_LINES 256
`define MPS_STACK_DEPTH 3

// ----------------------------------------------------------------
// Error codes and reset values
// ----------------------------------------------------------------
`define MPS_ERR_NONE 3'h0
`define MPS_ERR_NO_PROG 3'h1
`define MPS_ERR_NO_END 3'h2
`define MPS_ERR_NO_LABEL 3'h3
`define MPS_ERR_STACK_FULL 3'h4
`define MPS_ERR_STACK_EMPTY 3'h5
`define MPS_ERR_RUN_OFF 3'h6
`define MPS_GP_OUT_RESET 4'h0

`endif

// >>> hw/mps_pkg.sv
// Types shared by the motion program sequencer and its surroundings.
// Assumes the defines header is on the include path.
package mps_pkg;

  // ----------------------------------------------------------------
  // Program line layout
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LBL_NONE,
    LBL_PROGRAM,
    LBL_JUMP,
    LBL_SUBROUTINE
  } mps_label_kind_t;

  typedef enum logic [4:0] {
    CMD_NO_OPERATION,
    CMD_END_PROGRAM,
    CMD_TIMED_WAIT,
    CMD_TIMED_OUTPUT,
    CMD_INPUT_BRANCH,
    CMD_GOTO_LABEL,
    CMD_CALL_SUBROUTINE,
    CMD_SUBROUTINE_RETURN,
    CMD_ABSOLUTE_MOVE_WAIT,
    CMD_RELATIVE_MOVE_WAIT,
    CMD_RELATIVE_MOVE_START,
    CMD_POSITION_PASS_BRANCH,
    CMD_SET_POSITION,
    CMD_DUAL_AXIS_ABSOLUTE_MOVE,
    CMD_DUAL_AXIS_RELATIVE_MOVE,
    CMD_LINEAR_INTERP_MOVE,
    CMD_WAIT_DRIVE_END,
    CMD_DUAL_AXIS_HOME_SEARCH
  } mps_cmd_t;

  // One line holds both axis columns; labels live only in the first column
  typedef struct packed {
    mps_label_kind_t lbl_kind;
    logic [5:0] lbl_num;
    mps_cmd_t cmd;
    mps_cmd_t y_cmd;
    logic [1:0] port;
    logic level;
    logic [5:0] target;
    logic signed [31:0] x_data;
    logic signed [31:0] y_data;
  } mps_line_t;

  // ----------------------------------------------------------------
  // Request to one axis pulse engine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MK_ABSOLUTE,
    MK_RELATIVE,
    MK_HOME,
    MK_INTERP,
    MK_SET_POSITION
  } mps_move_kind_t;

  typedef struct packed {
    logic start;
    mps_move_kind_t kind;
    logic signed [31:0] value;
  } mps_axis_req_t;

endpackage

// >>> hw/mps_sequencer.sv
// Motion program sequencer: runs stored two-axis programs line by line.
// Assumes axis engines raise busy by the cycle after a start pulse,
// and that the program store is loaded while the sequencer is idle.
`timescale 1ns/100ps
`include "mps_defines.svh"

// Functional notes
// - Entry line carries the program label; jump search never matches it
// - Entry no-operation line then jump-labelled line allows jump to start
// - Jump labels after an end belong to preceding program label scope
// - Any number of end commands; first reached ends the program
// - Call transfers to the line holding the addressed subroutine label
// - Return resumes at the line after the invoking call
// - Return stack holds three nested call levels
// - Subroutine entry no-operation line then jump-labelled line is allowed
// - Dual move takes both columns of one line, own values each
// - Dual move advances only after both axes stop driving
// - Linear interpolation starts and advances at once
// - Wait-drive-end holds until all driving, interpolation included, ends
// - Input branch jumps when input equals level, else next line
// - Timed wait stalls for data milliseconds then advances
// - Timed output drives chosen output on for data milliseconds
// - Goto always transfers to the named jump label
// - Position-pass branch jumps once position passed value, else next line
// - Set position overwrites axis position with data value
// - Program without any end command is refused as invalid
// - Second-axis column ignored unless the line is a dual command
module mps_sequencer import mps_pkg::*; #(
  parameter int PROG_LINES = `MPS_PROG_LINES,
  parameter int STACK_DEPTH = `MPS_STACK_DEPTH,
  parameter int MS_CYCLES = `MPS_MS_NS / `MPS_CLK_NS
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic load_en,
  input wire logic [$clog2(PROG_LINES)-1:0] load_addr,
  input wire mps_line_t load_line,
  input wire logic start,
  input wire logic [5:0] start_prog,
  input wire logic [1:0] axis_busy,
  input wire logic signed [31:0] x_pos,
  input wire logic [3:0] gp_in,
  output mps_axis_req_t x_drive,
  output mps_axis_req_t y_drive,
  output logic [3:0] gp_out,
  output logic running,
  output logic done,
  output logic [2:0] error_code
);

  localparam int AW = $clog2(PROG_LINES);
  localparam int SW = $clog2(STACK_DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(PROG_LINES - 1);
  localparam logic [SW-1:0] FULL = SW'(STACK_DEPTH);
  localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (PROG_LINES < 2 || STACK_DEPTH < 2 || MS_CYCLES < 1) begin : g_bad
    $error("mps_sequencer: unsupported parameter values");
  end

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FIND,
    ST_CHECK_END,
    ST_EXEC,
    ST_SETTLE,
    ST_WAIT_DRIVE,
    ST_WAIT_TIME
  } mps_state_t;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  mps_line_t mem [PROG_LINES];
  logic [AW-1:0] ret_stk [STACK_DEPTH];
  logic [AW-1:0] scope_stk [STACK_DEPTH];

  mps_state_t state_r;
  logic [AW-1:0] pc_r;
  logic [AW-1:0] scan_r;
  logic [AW-1:0] scope_r;
  logic [SW-1:0] sp_r;
  mps_label_kind_t want_kind_r;
  logic [5:0] want_num_r;
  logic [31:0] tmr_r;
  logic [31:0] div_r;
  logic [1:0] out_port_r;
  mps_axis_req_t x_drv_r;
  mps_axis_req_t y_drv_r;
  logic [3:0] gp_out_r;
  logic run_r;
  logic done_r;
  logic [2:0] err_r;

  // A program or subroutine label opens a new scope
  function automatic logic is_scope_head(input mps_line_t ln);
    return ln.lbl_kind == LBL_PROGRAM || ln.lbl_kind == LBL_SUBROUTINE;
  endfunction

  // ----------------------------------------------------------------
  // Decode of the current and scanned lines
  // ----------------------------------------------------------------
  wire mps_line_t cur = mem[pc_r];
  wire mps_line_t scn = mem[scan_r];
  wire [AW-1:0] pc_inc = pc_r + AW'(1);
  wire at_last_pc = pc_r == LAST;
  wire at_last_scan = scan_r == LAST;
  wire scan_hit = scn.lbl_kind == want_kind_r && scn.lbl_num == want_num_r;
  // Jump search ends at the next scope head, so labels after an end stay owned
  wire scope_exit = want_kind_r == LBL_JUMP && is_scope_head(scn);
  wire in_match = gp_in[cur.port] == cur.level;
  wire pos_passed = cur.level ? (x_pos >= cur.x_data) : (x_pos <= cur.x_data);
  wire drive_idle = axis_busy == 2'b00;
  wire ms_tick = div_r == MS_LAST;
  wire stack_full = sp_r == FULL;
  wire stack_empty = sp_r == '0;
  wire [SW-1:0] sp_dec = sp_r - SW'(1);
  // Move kind shared by both axes on a dual line
  wire mps_move_kind_t dual_kind = cur.cmd == CMD_DUAL_AXIS_ABSOLUTE_MOVE ? MK_ABSOLUTE :
      cur.cmd == CMD_DUAL_AXIS_RELATIVE_MOVE ? MK_RELATIVE :
      cur.cmd == CMD_DUAL_AXIS_HOME_SEARCH ? MK_HOME : MK_INTERP;

  assign x_drive = x_drv_r;
  assign y_drive = y_drv_r;
  assign gp_out = gp_out_r;
  assign running = run_r;
  assign done = done_r;
  assign error_code = err_r;

  // ----------------------------------------------------------------
  // Program store, written only through the load port
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (load_en) begin
      mem[load_addr] <= load_line;
    end
  end

  // Millisecond divider, restarted on entry to each timed state
  always_ff @(posedge clock) begin
    if (!resetn || state_r != ST_WAIT_TIME || ms_tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      pc_r <= '0;
      scan_r <= '0;
      scope_r <= '0;
      sp_r <= '0;
      want_kind_r <= LBL_NONE;
      want_num_r <= 6'h0;
      tmr_r <= 32'h0;
      out_port_r <= 2'h0;
      x_drv_r <= '0;
      y_drv_r <= '0;
      gp_out_r <= `MPS_GP_OUT_RESET;
      run_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= `MPS_ERR_NONE;
    end else begin
      // Start strobes and done last one cycle only
      x_drv_r.start <= 1'b0;
      y_drv_r.start <= 1'b0;
      done_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            run_r <= 1'b1;
            err_r <= `MPS_ERR_NONE;
            sp_r <= '0;
            scan_r <= '0;
            want_kind_r <= LBL_PROGRAM;
            want_num_r <= start_prog;
            state_r <= ST_FIND;
          end
        end
        // One line per cycle; a miss ends the run with an error
        ST_FIND: begin
          if (scan_hit) begin
            pc_r <= scan_r;
            if (want_kind_r != LBL_JUMP) begin
              scope_r <= scan_r;
            end
            state_r <= want_kind_r == LBL_PROGRAM ? ST_CHECK_END : ST_EXEC;
          end else if (scope_exit || at_last_scan) begin
            err_r <= want_kind_r == LBL_PROGRAM ? `MPS_ERR_NO_PROG : `MPS_ERR_NO_LABEL;
            run_r <= 1'b0;
            state_r <= ST_IDLE;
          end else begin
            scan_r <= scan_r + AW'(1);
          end
        end
        // Scope must hold an end before anything runs
        ST_CHECK_END: begin
          if (scn.cmd == CMD_END_PROGRAM) begin
            state_r <= ST_EXEC;
          end else if ((scan_r != scope_r && is_scope_head(scn)) || at_last_scan) begin
            err_r <= `MPS_ERR_NO_END;
            run_r <= 1'b0;
            state_r <= ST_IDLE;
          end else begin
            scan_r <= scan_r + AW'(1);
          end
        end
        ST_EXEC: begin
          case (cur.cmd)
            // Entry lines may be empty so a jump label can follow
            CMD_NO_OPERATION: pc_r <= pc_inc;
            CMD_END_PROGRAM: begin
              run_r <= 1'b0;
              done_r <= 1'b1;
              state_r <= ST_IDLE;
            end
            CMD_TIMED_WAIT, CMD_TIMED_OUTPUT: begin
              if (cur.cmd == CMD_TIMED_OUTPUT) begin
                gp_out_r[cur.port] <= 1'b1;
              end
              out_port_r <= cur.port;
              tmr_r <= cur.x_data;
              state_r <= ST_WAIT_TIME;
            end
            CMD_INPUT_BRANCH, CMD_GOTO_LABEL, CMD_POSITION_PASS_BRANCH: begin
              // Search starts past the scope head, never on the entry line
              if (cur.cmd == CMD_GOTO_LABEL ||
                  (cur.cmd == CMD_INPUT_BRANCH && in_match) ||
                  (cur.cmd == CMD_POSITION_PASS_BRANCH && pos_passed)) begin
                scan_r <= scope_r + AW'(1);
                want_kind_r <= LBL_JUMP;
                want_num_r <= cur.target;
                state_r <= ST_FIND;
              end else begin
                pc_r <= pc_inc;
              end
            end
            CMD_CALL_SUBROUTINE: begin
              if (stack_full) begin
                err_r <= `MPS_ERR_STACK_FULL;
                run_r <= 1'b0;
                state_r <= ST_IDLE;
              end else begin
                ret_stk[sp_r[$clog2(STACK_DEPTH)-1:0]] <= pc_inc;
                scope_stk[sp_r[$clog2(STACK_DEPTH)-1:0]] <= scope_r;
                sp_r <= sp_r + SW'(1);
                scan_r <= '0;
                want_kind_r <= LBL_SUBROUTINE;
                want_num_r <= cur.target;
                state_r <= ST_FIND;
              end
            end
            CMD_SUBROUTINE_RETURN: begin
              if (stack_empty) begin
                err_r <= `MPS_ERR_STACK_EMPTY;
                run_r <= 1'b0;
                state_r <= ST_IDLE;
              end else begin
                pc_r <= ret_stk[sp_dec[$clog2(STACK_DEPTH)-1:0]];
                scope_r <= scope_stk[sp_dec[$clog2(STACK_DEPTH)-1:0]];
                sp_r <= sp_dec;
              end
            end
            // Single-axis commands use the first column only
            CMD_ABSOLUTE_MOVE_WAIT, CMD_RELATIVE_MOVE_WAIT: begin
              x_drv_r.start <= 1'b1;
              x_drv_r.kind <= cur.cmd == CMD_ABSOLUTE_MOVE_WAIT ? MK_ABSOLUTE : MK_RELATIVE;
              x_drv_r.value <= cur.x_data;
              state_r <= ST_SETTLE;
            end
            CMD_RELATIVE_MOVE_START, CMD_SET_POSITION: begin
              x_drv_r.start <= 1'b1;
              x_drv_r.kind <= cur.cmd == CMD_SET_POSITION ? MK_SET_POSITION : MK_RELATIVE;
              x_drv_r.value <= cur.x_data;
              pc_r <= pc_inc;
            end
            CMD_DUAL_AXIS_ABSOLUTE_MOVE, CMD_DUAL_AXIS_RELATIVE_MOVE,
            CMD_DUAL_AXIS_HOME_SEARCH, CMD_LINEAR_INTERP_MOVE: begin
              x_drv_r.start <= 1'b1;
              y_drv_r.start <= 1'b1;
              x_drv_r.value <= cur.x_data;
              y_drv_r.value <= cur.y_data;
              x_drv_r.kind <= dual_kind;
              y_drv_r.kind <= dual_kind;
              if (cur.cmd == CMD_LINEAR_INTERP_MOVE) begin
                pc_r <= pc_inc;
              end else begin
                state_r <= ST_SETTLE;
              end
            end
            CMD_WAIT_DRIVE_END: state_r <= ST_SETTLE;
            default: pc_r <= pc_inc;
          endcase
          // Falling off the store without an end is an error
          if (at_last_pc && cur.cmd != CMD_END_PROGRAM && state_r == ST_EXEC &&
              !(cur.cmd inside {CMD_GOTO_LABEL, CMD_CALL_SUBROUTINE,
                                CMD_SUBROUTINE_RETURN})) begin
            err_r <= `MPS_ERR_RUN_OFF;
            run_r <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        // One spare cycle lets busy rise after a start strobe
        ST_SETTLE: state_r <= ST_WAIT_DRIVE;
        ST_WAIT_DRIVE: begin
          if (drive_idle) begin
            pc_r <= pc_inc;
            state_r <= ST_EXEC;
          end
        end
        ST_WAIT_TIME: begin
          if (tmr_r == 32'h0) begin
            // Only a timed output raises a bit, so this clear is harmless after a wait
            gp_out_r[out_port_r] <= 1'b0;
            pc_r <= pc_inc;
            state_r <= ST_EXEC;
          end else if (ms_tick) begin
            tmr_r <= tmr_r - 32'h1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

endmodule

// >>> verification/mps_axis_model.sv
// Behavioural stand-in for the two axis pulse engines.
// Assumes one-cycle start pulses; busy rises on the edge that sees one.
`timescale 1ns/100ps
module mps_axis_model import mps_pkg::*; #(
  parameter int X_DLY = 6,
  parameter int Y_DLY = 9
) (
  input wire logic clock,
  input wire logic resetn,
  input wire mps_axis_req_t x_drive,
  input wire mps_axis_req_t y_drive,
  output logic [1:0] axis_busy,
  output logic signed [31:0] x_pos
);
  logic [7:0] x_cnt_r;
  logic [7:0] y_cnt_r;
  logic x_go;
  logic y_go;

  // Set-position never moves the motor, so it leaves busy low
  assign x_go = x_drive.start && x_drive.kind != MK_SET_POSITION;
  assign y_go = y_drive.start && y_drive.kind != MK_SET_POSITION;
  assign axis_busy = {y_cnt_r != 8'h00, x_cnt_r != 8'h00};

  // Unequal drive times so an early advance shows up
  always_ff @(posedge clock) begin
    if (!resetn) begin
      x_cnt_r <= 8'h00;
      y_cnt_r <= 8'h00;
    end else begin
      x_cnt_r <= x_go ? X_DLY[7:0] : x_cnt_r - (x_cnt_r != 8'h00);
      y_cnt_r <= y_go ? Y_DLY[7:0] : y_cnt_r - (y_cnt_r != 8'h00);
    end
  end

  // Position jumps to the target at once; timing is left to busy
  always_ff @(posedge clock) begin
    if (!resetn) begin
      x_pos <= 32'sh0;
    end else if (x_drive.start) begin
      case (x_drive.kind)
        MK_ABSOLUTE, MK_SET_POSITION: x_pos <= x_drive.value;
        MK_HOME: x_pos <= 32'sh0;
        default: x_pos <= x_pos + x_drive.value;
      endcase
    end
  end
endmodule

// >>> verification/mps_seq_properties.sv
// Port-level checker for the motion program sequencer.
// Assumes one clock domain and the active-low synchronous reset.
`timescale 1ns/100ps
module mps_seq_properties import mps_pkg::*; (
  input wire logic clock,
  input wire logic resetn,
  input wire logic start,
  input wire mps_axis_req_t x_drive,
  input wire mps_axis_req_t y_drive,
  input wire logic running,
  input wire logic done,
  input wire logic [2:0] error_code
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  // Start and stop; a stop needs a cause, reset excluded
  property p_start;
    start && !running |=> running;
  endproperty
  a_start: assert property (p_start) else $error("start in idle not taken");
  property p_done_stop;
    done |-> !running && error_code == 3'h0;
  endproperty
  a_done_stop: assert property (p_done_stop) else $error("done with run or error");
  property p_done_once;
    done |=> !done;
  endproperty
  a_done_once: assert property (p_done_once) else $error("done longer than one cycle");
  property p_idle_quiet;
    !running |-> !x_drive.start && !y_drive.start;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("drive pulse while idle");
  property p_stop_cause;
    $fell(running) && $past(resetn) |-> done || error_code != 3'h0;
  endproperty
  a_stop_cause: assert property (p_stop_cause) else $error("run stopped without cause");

  // ----------------------------------------------------------------
  // Errors and axis pairing
  // ----------------------------------------------------------------
  // Error is sticky until a new start, and always ends the run
  property p_err_hold;
    error_code != 3'h0 && !start |=> $stable(error_code);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error code changed");
  property p_run_err;
    error_code != 3'h0 |-> !running;
  endproperty
  a_run_err: assert property (p_run_err) else $error("running with error");
  property p_dual;
    y_drive.start |-> x_drive.start && y_drive.kind == x_drive.kind;
  endproperty
  a_dual: assert property (p_dual) else $error("second axis pulsed alone");
endmodule

bind mps_sequencer mps_seq_properties i_mps_seq_properties (
  .clock(clock),
  .resetn(resetn),
  .start(start),
  .x_drive(x_drive),
  .y_drive(y_drive),
  .running(running),
  .done(done),
  .error_code(error_code)
);

// >>> verification/tb.sv
// Self-checking bench for the motion program sequencer.
// Assumes the axis model on the far side and a shortened millisecond.
`timescale 1ns/100ps
module tb import mps_pkg::*; ;
  typedef struct {int pg; logic [3:0] gi; logic [2:0] err; logic dn; int xp; int nx; int ny;} mps_row_t;
  logic clock;
  logic resetn;
  logic load_en;
  logic [7:0] load_addr;
  mps_line_t load_line;
  logic start;
  logic [5:0] start_prog;
  logic [1:0] axis_busy;
  logic signed [31:0] x_pos;
  logic [3:0] gp_in;
  mps_axis_req_t x_drive;
  mps_axis_req_t y_drive;
  logic [3:0] gp_out;
  logic running;
  logic done;
  logic [2:0] error_code;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  int na = 0;
  int xs, ys, out_hi, ovl, ysum;
  logic got_done;
  mps_row_t rows [12] = '{
    '{1, 4'hf, 3'h0, 1, 100, 1, 0}, '{1, 4'he, 3'h0, 1, 205, 2, 0},
    '{2, 4'hf, 3'h0, 1, 216, 2, 0}, '{3, 4'hf, 3'h4, 0, 216, 0, 0},
    '{4, 4'hf, 3'h0, 1, 229, 3, 2}, '{5, 4'hf, 3'h2, 0, 229, 0, 0},
    '{9, 4'hf, 3'h1, 0, 229, 0, 0}, '{7, 4'hf, 3'h0, 1, 50, 1, 0},
    '{8, 4'hf, 3'h3, 0, 45, 2, 1}, '{10, 4'hf, 3'h5, 0, 45, 0, 0},
    '{11, 4'hf, 3'h6, 0, 45, 0, 0}, '{6, 4'hf, 3'h0, 1, 45, 0, 0}};

  mps_sequencer #(.MS_CYCLES(4)) i_mps_sequencer (.clock(clock), .resetn(resetn),
    .load_en(load_en), .load_addr(load_addr), .load_line(load_line), .start(start),
    .start_prog(start_prog), .axis_busy(axis_busy), .x_pos(x_pos), .gp_in(gp_in),
    .x_drive(x_drive), .y_drive(y_drive), .gp_out(gp_out), .running(running),
    .done(done), .error_code(error_code));
  mps_axis_model i_mps_axis_model (.clock(clock), .resetn(resetn), .x_drive(x_drive),
    .y_drive(y_drive), .axis_busy(axis_busy), .x_pos(x_pos));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One store line per call, addresses counted up
  task automatic ln(mps_label_kind_t k, int n, mps_cmd_t c, int t = 0, int xd = 0,
      int p = 0, int lv = 0, mps_cmd_t yc = CMD_NO_OPERATION, int yd = 0);
    @(negedge clock);
    load_en = 1;
    load_addr = na[7:0];
    load_line = '{k, n[5:0], c, yc, p[1:0], lv[0], t[5:0], xd, yd};
    na++;
  endtask

  // A second start while running must be ignored
  task automatic run(int pg, logic [3:0] gi, logic twice);
    @(negedge clock);
    gp_in = gi;
    start_prog = pg[5:0];
    start = 1;
    got_done = 0;
    xs = 0;
    ys = 0;
    out_hi = 0;
    ovl = 0;
    @(negedge clock);
    start = twice;
    start_prog = 6'h09;
    @(negedge clock);
    start = 0;
    for (int i = 0; i < 2000 && running; i++) @(negedge clock);
    @(negedge clock);
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and event counting
  // ----------------------------------------------------------------
  initial begin
    clock = 0;
    forever #25 clock = ~clock;
  end

  // Counts kept on the edge; all but cyc and ysum cleared by the driver on the falling edge
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (done) got_done <= 1;
    if (done) chk("busy at end", 0, axis_busy);
    if (x_drive.start) xs <= xs + 1;
    if (y_drive.start) ys <= ys + 1;
    if (y_drive.start) ysum <= ysum + y_drive.value;
    if (gp_out[1]) out_hi <= out_hi + 1;
    if (x_drive.start && axis_busy[1]) ovl <= ovl + 1;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 0;
    load_en = 0;
    load_addr = 8'h00;
    load_line = '0;
    start = 0;
    start_prog = 6'h00;
    gp_in = 4'hf;
    repeat (5) @(negedge clock);
    resetn = 1;
    chk("reset outputs", 0, {running, done, error_code, gp_out, x_drive.start});
    ln(LBL_PROGRAM, 1, CMD_NO_OPERATION);
    ln(LBL_JUMP, 1, CMD_RELATIVE_MOVE_WAIT, 0, 100);
    ln(LBL_NONE, 0, CMD_INPUT_BRANCH, 2, 0, 0, 0);
    ln(LBL_NONE, 0, CMD_END_PROGRAM);
    ln(LBL_JUMP, 2, CMD_TIMED_WAIT, 0, 1);
    ln(LBL_NONE, 0, CMD_RELATIVE_MOVE_WAIT, 0, 5);
    ln(LBL_NONE, 0, CMD_END_PROGRAM);
    ln(LBL_PROGRAM, 2, CMD_CALL_SUBROUTINE, 1);
    ln(LBL_NONE, 0, CMD_GOTO_LABEL, 3);
    ln(LBL_NONE, 0, CMD_RELATIVE_MOVE_WAIT, 0, 1000);
    ln(LBL_JUMP, 3, CMD_END_PROGRAM);
    ln(LBL_SUBROUTINE, 1, CMD_CALL_SUBROUTINE, 2);
    ln(LBL_NONE, 0, CMD_RELATIVE_MOVE_WAIT, 0, 10);
    ln(LBL_NONE, 0, CMD_SUBROUTINE_RETURN);
    ln(LBL_SUBROUTINE, 2, CMD_CALL_SUBROUTINE, 3);
    ln(LBL_NONE, 0, CMD_SUBROUTINE_RETURN);
    ln(LBL_SUBROUTINE, 3, CMD_RELATIVE_MOVE_WAIT, 0, 1);
    ln(LBL_NONE, 0, CMD_SUBROUTINE_RETURN);
    ln(LBL_PROGRAM, 3, CMD_CALL_SUBROUTINE, 4);
    ln(LBL_NONE, 0, CMD_END_PROGRAM);
    ln(LBL_SUBROUTINE, 4, CMD_CALL_SUBROUTINE, 4);
    ln(LBL_PROGRAM, 4, CMD_DUAL_AXIS_RELATIVE_MOVE, 0, 7, 0, 0, CMD_DUAL_AXIS_RELATIVE_MOVE, -3);
    ln(LBL_NONE, 0, CMD_RELATIVE_MOVE_START, 0, 2, 0, 0, CMD_RELATIVE_MOVE_START, 8);
    ln(LBL_NONE, 0, CMD_LINEAR_INTERP_MOVE, 0, 4, 0, 0, CMD_LINEAR_INTERP_MOVE, 6);
    ln(LBL_NONE, 0, CMD_WAIT_DRIVE_END);
    ln(LBL_NONE, 0, CMD_END_PROGRAM);
    ln(LBL_PROGRAM, 5, CMD_NO_OPERATION);
    ln(LBL_PROGRAM, 6, CMD_TIMED_OUTPUT, 0, 2, 1);
    ln(LBL_NONE, 0, CMD_END_PROGRAM);
    ln(LBL_PROGRAM, 7, CMD_SET_POSITION, 0, 50);
    ln(LBL_NONE, 0, CMD_NO_OPERATION);
    ln(LBL_NONE, 0, CMD_POSITION_PASS_BRANCH, 2, 60, 0, 0);
    ln(LBL_NONE, 0, CMD_RELATIVE_MOVE_WAIT, 0, 1000);
    ln(LBL_JUMP, 2, CMD_END_PROGRAM);
    // Dual absolute, untaken position branch, taken branch to a missing label
    ln(LBL_PROGRAM, 8, CMD_DUAL_AXIS_ABSOLUTE_MOVE, 0, 40, 0, 0, CMD_DUAL_AXIS_ABSOLUTE_MOVE, 9);
    ln(LBL_NONE, 0, CMD_ABSOLUTE_MOVE_WAIT, 0, 45);
    ln(LBL_NONE, 0, CMD_POSITION_PASS_BRANCH, 6, 60, 0, 1);
    ln(LBL_NONE, 0, CMD_INPUT_BRANCH, 5, 0, 1, 1);
    ln(LBL_JUMP, 6, CMD_END_PROGRAM);
    ln(LBL_SUBROUTINE, 5, CMD_SUBROUTINE_RETURN);
    ln(LBL_PROGRAM, 10, CMD_SUBROUTINE_RETURN);
    ln(LBL_NONE, 0, CMD_END_PROGRAM);
    // Last store line reached without an end
    na = 253;
    ln(LBL_PROGRAM, 11, CMD_INPUT_BRANCH, 7, 0, 0, 1);
    ln(LBL_NONE, 0, CMD_END_PROGRAM);
    ln(LBL_JUMP, 7, CMD_NO_OPERATION);
    @(negedge clock);
    load_en = 0;
    // Table of whole program runs
    foreach (rows[i]) begin
      run(rows[i].pg, rows[i].gi, 0);
      chk("error code", rows[i].err, error_code);
      chk("done seen", rows[i].dn, got_done);
      chk("position", rows[i].xp, x_pos);
      chk("first axis starts", rows[i].nx, xs);
      chk("second axis starts", rows[i].ny, ys);
      chk("early advance", 0, ovl);
    end
    chk("pulse length ok", 1, out_hi >= 8 && out_hi <= 10);
    chk("second axis values", 12, ysum);
    run(2, 4'hf, 1);
    chk("restart ignored", 4'h1, {error_code, got_done});
    // Reset in the middle of a timed pulse must drop the output
    @(negedge clock);
    start_prog = 6'h06;
    start = 1;
    @(negedge clock);
    start = 0;
    repeat (34) @(negedge clock);
    chk("output on", 4'h2, gp_out);
    resetn = 0;
    @(negedge clock);
    resetn = 1;
    chk("reset mid run", 0, {running, gp_out, done});
    summarize();
  end
endmodule
